// file: common/xmp_map.vh
// Purpose: address map, field positions and timing counts of the external memory port
// Assumes: nibble-wide data memory space with 12-bit addresses
// Notes: definitions only
`ifndef XMP_MAP_VH
`define XMP_MAP_VH
// ----------------------------------------
// register addresses
// ----------------------------------------
`define XMP_ADDR_CTRL_LO 12'hFD2
`define XMP_ADDR_CTRL_HI 12'hFD3
`define XMP_ADDR_AL_LO 12'hFD4
`define XMP_ADDR_AL_HI 12'hFD5
`define XMP_ADDR_AM_LO 12'hFD6
`define XMP_ADDR_AM_HI 12'hFD7
`define XMP_ADDR_AH_LO 12'hFD8
`define XMP_ADDR_AH_HI 12'hFD9
`define XMP_ADDR_DAT_LO 12'hFDA
`define XMP_ADDR_DAT_HI 12'hFDB
// ----------------------------------------
// control fields
// ----------------------------------------
`define XMP_BIT_START 0
`define XMP_SEL_LSB 1
`define XMP_SEL_MSB 3
`define XMP_BIT_INC 4
`define XMP_CLK_LSB 5
`define XMP_CLK_MSB 6
`define XMP_BIT_DIR 7
`define XMP_CTRL_RESET 8'h00
`define XMP_ADDR_RESET 19'h00000
`define XMP_DATA_RESET 8'h00
`define XMP_SEL_LAST 3'h5
// ----------------------------------------
// timing
// ----------------------------------------
`define XMP_PHASES 3'h4
`define XMP_DIV_LAST_8 3'h7
`define XMP_DIV_LAST_4 3'h3
`define XMP_DIV_LAST_2 3'h1
`define XMP_DIV_LAST_1 3'h0
`endif

// file: hw/xmp_clock_div.v
// Purpose: access clock tick generator for the external memory port
// Assumes: tick restarts whenever the access engine is idle
// Notes: one tick per access clock period
`timescale 1ns/1ns
`default_nettype none
`include "xmp_map.vh"
module xmp_clock_div
(
  input wire i_clock,
  input wire i_rst_n,
  input wire i_run, // high while an access is in progress
  input wire [1:0] i_clk_sel, // access clock code
  output reg o_tick // one-cycle pulse per access clock
);
  // ----------------------------------------
  // divider
  // ----------------------------------------
  reg [2:0] count; // cycles since last tick
  reg [2:0] last; // terminal count for the chosen ratio

  // decode ratio: 00 /8, 01 /4, 10 /2, 11 /1
  always @*
  begin
    case (i_clk_sel)
      2'h0: last = `XMP_DIV_LAST_8;
      2'h1: last = `XMP_DIV_LAST_4;
      2'h2: last = `XMP_DIV_LAST_2;
      default: last = `XMP_DIV_LAST_1;
    endcase
  end

  // free counter restarted when idle so every access has full phases
  always @(posedge i_clock)
  begin
    if (!i_rst_n || !i_run)
    begin
      count <= 3'h0;
      o_tick <= 1'b0;
    end
    else if (count >= last)
    begin
      count <= 3'h0;
      o_tick <= 1'b1;
    end
    else
    begin
      count <= count + 3'h1;
      o_tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: hw/xmp_port.v
// Purpose: register-driven single-access controller for external parallel memories
// Assumes: nibble-wide register port, synchronous inputs, one clock
// Notes: address and data pins are shared with the LCD segment drivers outside this block
// Function
// - six memory selects, one per device
// - eight data lines, nineteen address lines
// - direction bit: 0 read, 1 write
// - clock field divides system clock 8/4/2/1
// - auto-increment address after each access
// - select code 0-5 picks one select
// - read captures byte into data register
// - write drives data register onto bus
// - control written as two nibbles, low first
// - address and data pins shared with LCD
`timescale 1ns/1ns
`default_nettype none
`include "xmp_map.vh"
module xmp_port
(
  input wire i_clock,
  input wire i_rst_n,
  input wire [11:0] i_reg_addr, // nibble register address
  input wire i_reg_wr, // write strobe, one cycle
  input wire [3:0] i_reg_wdata, // nibble write data
  output reg [3:0] o_reg_rdata, // nibble read data, registered
  output reg [18:0] o_ext_address_bus, // memory address
  input wire [7:0] i_ext_data_bus, // data pins as seen
  output reg [7:0] o_ext_data_bus, // data pins driven value
  output reg o_ext_data_bus_oe, // high while driving data pins
  output reg o_read_strobe_n, // read strobe, low active
  output reg o_write_strobe_n, // write strobe, low active
  output reg [5:0] o_memory_select_outputs_n, // chip selects, low active
  output reg o_lcd_pins_busy // tells pin mux that shared pins belong to memory
);
  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam ST_IDLE = 2'h0;
  localparam ST_SETUP = 2'h1; // address and select stable
  localparam ST_STROBE = 2'h2; // strobe active
  localparam ST_HOLD = 2'h3; // strobe released, hold lines

  reg [1:0] state; // engine state
  reg [1:0] next_state;
  reg [7:0] ext_mem_control; // control register
  reg [18:0] ext_addr; // ext_addr_low/mid/high packed
  reg [7:0] ext_data_byte; // data register
  reg [3:0] ctrl_low_pend; // low nibble waiting for high
  reg ctrl_low_valid; // low nibble written
  wire tick; // access clock tick
  wire busy; // access underway
  wire dir_write; // direction bit
  wire [2:0] sel_code; // select field
  wire [5:0] sel_onehot; // decoded select
  reg [3:0] rd_mux; // read data before register
  wire access_done; // last phase ends

  assign busy = (state != ST_IDLE);
  assign dir_write = ext_mem_control[`XMP_BIT_DIR];
  assign sel_code = ext_mem_control[`XMP_SEL_MSB:`XMP_SEL_LSB];
  assign access_done = (state == ST_HOLD) && tick;

  // ----------------------------------------
  // access clock
  // ----------------------------------------
  xmp_clock_div u_div
  (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_run(busy),
    .i_clk_sel(ext_mem_control[`XMP_CLK_MSB:`XMP_CLK_LSB]),
    .o_tick(tick)
  );

  // ----------------------------------------
  // select decode
  // ----------------------------------------
  // one generate loop builds the one-hot; codes 6 and 7 select nothing
  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1)
    begin : g_sel
      // one continuous driver per bit keeps each select bit single-sourced
      assign sel_onehot[g] = (sel_code == g);
    end
  endgenerate

  // ----------------------------------------
  // control register
  // ----------------------------------------
  // low nibble is held until the high nibble arrives, so the byte lands
  // at once; a high write with no low nibble pending keeps the old low fields
  always @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      ext_mem_control <= `XMP_CTRL_RESET;
      ctrl_low_pend <= 4'h0;
      ctrl_low_valid <= 1'b0;
    end
    else
    begin
      // completion clears start; a write in the same cycle is ignored
      // because fields must not change during an access
      if (access_done)
      begin
        ext_mem_control[`XMP_BIT_START] <= 1'b0;
      end
      if (i_reg_wr && i_reg_addr == `XMP_ADDR_CTRL_LO)
      begin
        ctrl_low_pend <= i_reg_wdata;
        ctrl_low_valid <= 1'b1;
      end
      else if (i_reg_wr && i_reg_addr == `XMP_ADDR_CTRL_HI && !busy)
      begin
        // fields locked while busy; start only accepted when idle
        ext_mem_control <= {i_reg_wdata, (ctrl_low_valid ? ctrl_low_pend : ext_mem_control[3:0])};
        ctrl_low_valid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // address and data registers
  // ----------------------------------------
  // software writes are ignored while busy so the engine owns them
  always @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      ext_addr <= `XMP_ADDR_RESET;
      ext_data_byte <= `XMP_DATA_RESET;
    end
    else if (busy)
    begin
      if (state == ST_STROBE && tick && !dir_write)
      begin
        ext_data_byte <= i_ext_data_bus;
      end
      if (access_done && ext_mem_control[`XMP_BIT_INC])
      begin
        ext_addr <= ext_addr + 19'h00001;
      end
    end
    else if (i_reg_wr)
    begin
      case (i_reg_addr)
        `XMP_ADDR_AL_LO: ext_addr[3:0] <= i_reg_wdata;
        `XMP_ADDR_AL_HI: ext_addr[7:4] <= i_reg_wdata;
        `XMP_ADDR_AM_LO: ext_addr[11:8] <= i_reg_wdata;
        `XMP_ADDR_AM_HI: ext_addr[15:12] <= i_reg_wdata;
        `XMP_ADDR_AH_LO: ext_addr[18:16] <= i_reg_wdata[2:0];
        `XMP_ADDR_DAT_LO: ext_data_byte[3:0] <= i_reg_wdata;
        `XMP_ADDR_DAT_HI: ext_data_byte[7:4] <= i_reg_wdata;
        default: ext_addr <= ext_addr;
      endcase
    end
  end

  // ----------------------------------------
  // engine
  // ----------------------------------------
  // three access-clock phases: setup, strobe, hold, then back to idle
  always @*
  begin
    next_state = state;
    case (state)
      ST_IDLE:
      begin
        if (ext_mem_control[`XMP_BIT_START])
        begin
          next_state = ST_SETUP;
        end
      end
      ST_SETUP:
      begin
        if (tick)
        begin
          next_state = ST_STROBE;
        end
      end
      ST_STROBE:
      begin
        if (tick)
        begin
          next_state = ST_HOLD;
        end
      end
      ST_HOLD:
      begin
        if (tick)
        begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // state register
  always @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      state <= ST_IDLE;
    end
    else
    begin
      state <= next_state;
    end
  end

  // ----------------------------------------
  // pins
  // ----------------------------------------
  // all pin outputs come from flops; selects idle high like the port latch
  always @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      o_ext_address_bus <= `XMP_ADDR_RESET;
      o_ext_data_bus <= `XMP_DATA_RESET;
      o_ext_data_bus_oe <= 1'b0;
      o_read_strobe_n <= 1'b1;
      o_write_strobe_n <= 1'b1;
      o_memory_select_outputs_n <= 6'h3F;
      o_lcd_pins_busy <= 1'b0;
    end
    else
    begin
      o_ext_address_bus <= ext_addr;
      o_ext_data_bus <= ext_data_byte;
      o_ext_data_bus_oe <= (next_state != ST_IDLE) && dir_write;
      o_read_strobe_n <= !((next_state == ST_STROBE) && !dir_write);
      o_write_strobe_n <= !((next_state == ST_STROBE) && dir_write);
      o_memory_select_outputs_n <= (next_state != ST_IDLE) ? ~sel_onehot : 6'h3F;
      o_lcd_pins_busy <= (next_state != ST_IDLE);
    end
  end

  // ----------------------------------------
  // read back
  // ----------------------------------------
  // start bit reads as busy; unmapped addresses read zero
  always @*
  begin
    case (i_reg_addr)
      // start bit is or-ed in so a poll right after the start write never sees a false idle
      `XMP_ADDR_CTRL_LO: rd_mux = {ext_mem_control[3:1], busy | ext_mem_control[`XMP_BIT_START]};
      `XMP_ADDR_CTRL_HI: rd_mux = ext_mem_control[7:4];
      `XMP_ADDR_AL_LO: rd_mux = ext_addr[3:0];
      `XMP_ADDR_AL_HI: rd_mux = ext_addr[7:4];
      `XMP_ADDR_AM_LO: rd_mux = ext_addr[11:8];
      `XMP_ADDR_AM_HI: rd_mux = ext_addr[15:12];
      `XMP_ADDR_AH_LO: rd_mux = {1'b0, ext_addr[18:16]};
      `XMP_ADDR_DAT_LO: rd_mux = ext_data_byte[3:0];
      `XMP_ADDR_DAT_HI: rd_mux = ext_data_byte[7:4];
      default: rd_mux = 4'h0;
    endcase
  end

  // registered read data, valid the cycle after the address
  always @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      o_reg_rdata <= 4'h0;
    end
    else
    begin
      o_reg_rdata <= rd_mux;
    end
  end
endmodule
`default_nettype wire

// file: verif/xmp_port_asserts.sv
// Purpose: port-level checks of the external memory port
// Assumes: one clock, synchronous low reset
// Notes: bound to every xmp_port instance
`timescale 1ns/1ns
`default_nettype none
module xmp_port_asserts
(
  input wire i_clock,
  input wire i_rst_n,
  input wire [11:0] i_reg_addr,
  input wire i_reg_wr,
  input wire [3:0] i_reg_wdata,
  input wire [3:0] o_reg_rdata,
  input wire [18:0] o_ext_address_bus,
  input wire [7:0] i_ext_data_bus,
  input wire [7:0] o_ext_data_bus,
  input wire o_ext_data_bus_oe,
  input wire o_read_strobe_n,
  input wire o_write_strobe_n,
  input wire [5:0] o_memory_select_outputs_n,
  input wire o_lcd_pins_busy
);
  // ------
  // pin relations
  // ------
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  a_one_select:
    assert property ($countones(~o_memory_select_outputs_n) <= 1) else $error("two selects low");
  a_strobe_exclusive:
    assert property (o_read_strobe_n || o_write_strobe_n) else $error("both strobes low");
  a_strobe_selected:
    assert property (!(o_read_strobe_n && o_write_strobe_n) |-> o_memory_select_outputs_n != 6'h3F)
    else $error("strobe without select");
  a_write_drives:
    assert property (!o_write_strobe_n |-> o_ext_data_bus_oe && $stable(o_ext_data_bus)) else $error("write not driven");
  a_read_released:
    assert property (!o_read_strobe_n |-> !o_ext_data_bus_oe) else $error("read while driving");
  a_strobe_width:
    assert property ($fell(o_read_strobe_n) || $fell(o_write_strobe_n) |-> ##[1:8] (o_read_strobe_n && o_write_strobe_n))
    else $error("strobe too long");
  a_addr_held:
    assert property ($rose(o_read_strobe_n) || $rose(o_write_strobe_n) |->
      $stable(o_ext_address_bus) && $stable(o_memory_select_outputs_n)) else $error("address moved in strobe");
  a_pins_owned:
    assert property (o_memory_select_outputs_n != 6'h3F || o_ext_data_bus_oe |-> o_lcd_pins_busy)
    else $error("pins used while free");
  a_reset_idle:
    assert property ($rose(i_rst_n) |-> o_memory_select_outputs_n == 6'h3F && o_read_strobe_n && o_write_strobe_n)
    else $error("not idle after reset");
endmodule
bind xmp_port xmp_port_asserts u_chk (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_reg_addr(i_reg_addr),
  .i_reg_wr(i_reg_wr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .o_ext_address_bus(o_ext_address_bus),
  .i_ext_data_bus(i_ext_data_bus), .o_ext_data_bus(o_ext_data_bus), .o_ext_data_bus_oe(o_ext_data_bus_oe),
  .o_read_strobe_n(o_read_strobe_n), .o_write_strobe_n(o_write_strobe_n),
  .o_memory_select_outputs_n(o_memory_select_outputs_n), .o_lcd_pins_busy(o_lcd_pins_busy));
`default_nettype wire

// file: verif/xmp_sram_model.sv
// Purpose: six byte-wide memories behind the select lines
// Assumes: write taken at the rising write strobe
// Notes: released data lines show inverted data, never a held value
`timescale 1ns/1ns
`default_nettype none
module xmp_sram_model
#(
  parameter int ACCESS_NS = 1 // read access time
)
(
  input wire logic [18:0] i_address,
  input wire logic [7:0] i_data,
  input wire logic [5:0] i_select_n,
  input wire logic i_read_strobe_n,
  input wire logic i_write_strobe_n,
  output logic [7:0] o_data
);
  logic [7:0] mem [int]; // sparse store, device index above address
  int key; // -1 when no device is selected
  initial o_data = 8'h5A;
  // a select counts only when low; idle selects sit at the latched high level
  always @*
  begin
    key = -1;
    for (int k = 0; k < 6; k++)
      if (!i_select_n[k])
        key = k * 524288 + int'(i_address);
  end
  always @(posedge i_write_strobe_n)
    if (key >= 0)
      mem[key] = i_data;
  // unwritten places answer a fixed pattern
  always @(negedge i_read_strobe_n)
  begin
    #(ACCESS_NS);
    o_data = (key >= 0 && mem.exists(key)) ? mem[key] : 8'hC3;
  end
  // inverted after release so a late sample cannot pass
  always @(posedge i_read_strobe_n)
    #1 o_data = ~o_data;
endmodule
`default_nettype wire

// file: verif/xmp_tb.sv
// Purpose: self-checking bench of the external memory port
// Assumes: 250 MHz clock, synchronous low reset
// Notes: software sequences run as nibble register writes
`timescale 1ns/1ns
`default_nettype none
`include "xmp_map.vh"
`define CHK(g, e) \
  begin \
    total_checks++; \
    if ((g) !== (e)) \
    begin \
      fail_count++; \
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); \
    end \
  end
module testbench;
  logic i_clock = 1'b0;
  logic i_rst_n = 1'b0;
  logic [11:0] i_reg_addr = 12'h000;
  logic i_reg_wr = 1'b0;
  logic [3:0] i_reg_wdata = 4'h0;
  wire [3:0] rdata;
  wire [18:0] addr;
  wire [7:0] dout;
  wire [7:0] mem_q;
  wire oe, rd_n, wr_n, pins_busy;
  wire [5:0] sel_n;
  int fail_count = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [7:0] b;
  wire [7:0] bus = oe ? dout : mem_q;
  always #2 i_clock = ~i_clock;
  xmp_port dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
    .i_reg_wdata(i_reg_wdata), .o_reg_rdata(rdata), .o_ext_address_bus(addr), .i_ext_data_bus(bus),
    .o_ext_data_bus(dout), .o_ext_data_bus_oe(oe), .o_read_strobe_n(rd_n), .o_write_strobe_n(wr_n),
    .o_memory_select_outputs_n(sel_n), .o_lcd_pins_busy(pins_busy));
  xmp_sram_model #(.ACCESS_NS(1)) mem (.i_address(addr), .i_data(bus), .i_select_n(sel_n),
    .i_read_strobe_n(rd_n), .i_write_strobe_n(wr_n), .o_data(mem_q));
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // hang guard: the whole run needs about 450 cycles
  always @(posedge i_clock)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fail_count++;
      results();
    end
  end
  // ------
  // register access
  // ------
  task automatic wr_byte(input logic [11:0] a, input logic [7:0] v);
    @(posedge i_clock);
    i_reg_addr <= a;
    i_reg_wdata <= v[3:0];
    i_reg_wr <= 1'b1;
    @(posedge i_clock);
    i_reg_addr <= a + 12'h001;
    i_reg_wdata <= v[7:4];
    @(posedge i_clock);
    i_reg_wr <= 1'b0;
    i_reg_addr <= `XMP_ADDR_CTRL_LO; // park on busy bit
  endtask
  task automatic rd_byte(input logic [11:0] a, output logic [7:0] v);
    @(posedge i_clock);
    i_reg_addr <= a;
    @(posedge i_clock);
    i_reg_addr <= a + 12'h001;
    #1 v[3:0] = rdata;
    @(posedge i_clock);
    #1 v[7:4] = rdata;
  endtask
  task automatic set_addr(input logic [18:0] a);
    wr_byte(`XMP_ADDR_AL_LO, a[7:0]);
    wr_byte(`XMP_ADDR_AM_LO, a[15:8]);
    wr_byte(`XMP_ADDR_AH_LO, {5'h00, a[18:16]});
  endtask
  // program, wait set-up, start, poll; watch the pins meanwhile
  task automatic access(input logic [7:0] c);
    int nrd, nwr, n;
    logic [5:0] seen;
    logic drv, bz, pb;
    nrd = 0;
    nwr = 0;
    seen = 6'h3F;
    drv = 1'b0;
    bz = 1'b0;
    pb = 1'b0;
    wr_byte(`XMP_ADDR_CTRL_LO, c);
    repeat (4) @(posedge i_clock);
    wr_byte(`XMP_ADDR_CTRL_LO, c | 8'h01);
    for (n = 0; n < 100; n++)
    begin
      @(posedge i_clock);
      #1;
      nrd += (rd_n === 1'b0);
      nwr += (wr_n === 1'b0);
      seen &= sel_n;
      drv |= oe;
      bz |= rdata[0];
      pb |= pins_busy;
      if (n > 2 && rdata[0] === 1'b0)
        break;
    end
    `CHK(c[7] ? nwr : nrd, 8 >> c[6:5])
    `CHK(c[7] ? nrd : nwr, 0)
    `CHK(seen, ~(6'h01 << c[3:1]))
    `CHK(drv, c[7])
    `CHK(bz, 1'b1)
    `CHK(rdata[0], 1'b0)
    `CHK(pb, 1'b1)
  endtask
  initial
  begin
    repeat (12) @(posedge i_clock);
    i_rst_n <= 1'b1;
    rd_byte(`XMP_ADDR_CTRL_LO, b);
    `CHK(b, `XMP_CTRL_RESET)
    `CHK(sel_n, 6'h3F)
    `CHK(mem_q !== 8'hXX, 1'b1)
    set_addr(19'h40000);
    wr_byte(`XMP_ADDR_DAT_LO, 8'h38);
    access(8'h92);
    `CHK(addr, 19'h40001)
    for (int i = 0; i < 6; i++)
    begin
      wr_byte(`XMP_ADDR_DAT_LO, 8'(8'hA0 + i));
      access({1'b1, 2'(i), 1'b0, 3'(i), 1'b0});
    end
    `CHK(addr, 19'h40001)
    for (int i = 0; i < 6; i++)
    begin
      access({1'b0, 2'(i + 1), 1'b0, 3'(i), 1'b0});
      rd_byte(`XMP_ADDR_DAT_LO, b);
      `CHK(b, 8'(8'hA0 + i))
    end
    set_addr(19'h40000);
    access(8'h72);
    rd_byte(`XMP_ADDR_DAT_LO, b);
    `CHK(b, 8'h38)
    set_addr(19'h7FFFF);
    access(8'h70);
    `CHK(addr, 19'h00000)
    results();
  end
endmodule
`default_nettype wire
